// ### hdl/iop_ports34.sv
// port 3 pin control and port 4 data/direction with a classic wishbone slave
`timescale 1ns/1ps

// Overview of operation
// - pins 3.7-3.3 float in reset, float in standby unless pulled up, hold in sleep, subsleep and watch
// - in standby a port 3 pin with pull-up on drives high
// - port 3 pull-up on only when direction is 0 and control is 1
// - every port 3 pull-up is off after reset
// - port 4 has three two-way pins and one input-only pin
// - port 4 data resets to f8, top four bits read one, bit 3 read-only
// - port 4 data bit with direction 1 reads the latched value
// - port 4 data bit with direction 0 reads the pin level
// - port 4 direction 1 makes an output, 0 an input
// - port 4 settings act only while the serial control selects general use
// - port 4 direction register is write-only and reads all ones
// - port 4 direction resets to f8, pins start as inputs
module iop_ports34 (
  input logic sys_clk,
  input logic resetn,
  input logic [17:0] wb_adr_i,
  input logic [31:0] wb_dat_i,
  input logic [3:0] wb_sel_i,
  input logic wb_we_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input logic [7:0] p3_pin_i,
  output logic [7:0] p3_pin_o,
  output logic [7:0] p3_pin_oe,
  output logic [7:0] p3_pullup_o,
  input logic [2:0] p4_pin_i,
  input logic p4_in3_i,
  output logic [2:0] p4_pin_o,
  output logic [2:0] p4_pin_oe,
  input logic pwm_level_i,
  output logic count_dir_o
);

  localparam iop_pkg::iop_state_s ST_RST = '{
    ack: 1'b0,
    rdata: 32'h0000_0000,
    p3_dat: iop_pkg::P3_RST,
    p3_dir: iop_pkg::P3_RST,
    p3_puc: iop_pkg::P3_RST,
    pwm_sel: 1'b0,
    ud_sel: 1'b0,
    p4_dat: iop_pkg::P4_DATA_RST[2:0],
    p4_dir: iop_pkg::P4_DIR_RST[2:0],
    ser_gp: iop_pkg::SER_GP_RST,
    mode: iop_pkg::MODE_ACTIVE,
    p3: '0,
    p4_out: 3'h0,
    p4_oe: 3'h0,
    ud_in: 1'b0
  };

  iop_pkg::iop_state_s st_r;
  iop_pkg::iop_state_s st_nxt;

  logic [11:0] pin_w;
  logic [7:0] p3_in_w;
  logic [2:0] p4_in_w;
  logic p4_in3_w;
  iop_pkg::iop_pin_s p3_nxt_w;
  logic req_w;
  logic first_w;
  logic wr_w;
  logic [7:0] wd_w;
  logic [2:0] p4_live_w;
  logic [7:0] p4_rd_w;
  logic [7:0] p3_rd_w;
  logic [31:0] rd_w;

  function automatic logic hit(input logic [17:0] a, input logic [15:0] idx);
    return a == {idx, 2'b00};
  endfunction

  // all pin inputs are asynchronous to sys_clk
  iop_sync2 u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .d({p4_in3_i, p4_pin_i, p3_pin_i}),
    .q(pin_w)
  );

  assign p3_in_w = pin_w[7:0];
  assign p4_in_w = pin_w[10:8];
  assign p4_in3_w = pin_w[11];

  iop_p3_pins u_p3 (
    .dir(st_r.p3_dir),
    .dat(st_r.p3_dat),
    .puc(st_r.p3_puc),
    .pwm_sel(st_r.pwm_sel),
    .ud_sel(st_r.ud_sel),
    .pwm_level(pwm_level_i),
    .mode(st_r.mode),
    .prev(st_r.p3),
    .nxt(p3_nxt_w)
  );

  // bus handshake: data latched on the first cycle, write lands on the edge that ends the ack cycle
  assign req_w = wb_cyc_i & wb_stb_i;
  assign first_w = req_w & ~st_r.ack;
  assign wr_w = req_w & st_r.ack & wb_we_i & wb_sel_i[0];
  assign wd_w = wb_dat_i[7:0];

  // a port 4 pin reads its latch only when it is a general output
  assign p4_live_w = st_r.p4_dir & st_r.ser_gp;

  always_comb begin
    p4_rd_w[7:4] = iop_pkg::P4_RD_HIGH;
    p4_rd_w[3] = p4_in3_w;
    for (int i = 0; i < 3; i++) begin
      p4_rd_w[i] = p4_live_w[i] ? st_r.p4_dat[i] : p4_in_w[i];
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      p3_rd_w[i] = st_r.p3_dir[i] ? st_r.p3_dat[i] : p3_in_w[i];
    end
  end

  always_comb begin
    rd_w = 32'h0000_0000;
    if (hit(wb_adr_i, iop_pkg::IDX_P4_DATA)) begin
      rd_w[7:0] = p4_rd_w;
    end else if (hit(wb_adr_i, iop_pkg::IDX_P4_DIR)) begin
      rd_w[7:0] = iop_pkg::P4_DIR_RD;
    end else if (hit(wb_adr_i, iop_pkg::IDX_P3_DATA)) begin
      rd_w[7:0] = p3_rd_w;
    end else if (hit(wb_adr_i, iop_pkg::IDX_P3_DIR)) begin
      rd_w[7:0] = st_r.p3_dir;
    end else if (hit(wb_adr_i, iop_pkg::IDX_P3_PUC)) begin
      rd_w[7:0] = st_r.p3_puc;
    end else if (hit(wb_adr_i, iop_pkg::IDX_P3_FUNC)) begin
      rd_w[iop_pkg::FUNC_PWM_BIT] = st_r.pwm_sel;
      rd_w[iop_pkg::FUNC_UD_BIT] = st_r.ud_sel;
    end else if (hit(wb_adr_i, iop_pkg::IDX_SER_GP)) begin
      rd_w[2:0] = st_r.ser_gp;
    end else if (hit(wb_adr_i, iop_pkg::IDX_PWR)) begin
      rd_w[2:0] = st_r.mode;
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = first_w;
    if (first_w) begin
      st_nxt.rdata = rd_w;
    end
    if (wr_w) begin
      if (hit(wb_adr_i, iop_pkg::IDX_P4_DATA)) begin
        st_nxt.p4_dat = wd_w[2:0];
      end
      if (hit(wb_adr_i, iop_pkg::IDX_P4_DIR)) begin
        st_nxt.p4_dir = wd_w[2:0];
      end
      if (hit(wb_adr_i, iop_pkg::IDX_P3_DATA)) begin
        st_nxt.p3_dat = wd_w;
      end
      if (hit(wb_adr_i, iop_pkg::IDX_P3_DIR)) begin
        st_nxt.p3_dir = wd_w;
      end
      if (hit(wb_adr_i, iop_pkg::IDX_P3_PUC)) begin
        st_nxt.p3_puc = wd_w;
      end
      if (hit(wb_adr_i, iop_pkg::IDX_P3_FUNC)) begin
        st_nxt.pwm_sel = wd_w[iop_pkg::FUNC_PWM_BIT];
        st_nxt.ud_sel = wd_w[iop_pkg::FUNC_UD_BIT];
      end
      if (hit(wb_adr_i, iop_pkg::IDX_SER_GP)) begin
        st_nxt.ser_gp = wd_w[2:0];
      end
      if (hit(wb_adr_i, iop_pkg::IDX_PWR)) begin
        st_nxt.mode = iop_pkg::iop_mode_e'(wd_w[2:0]);
      end
    end
    st_nxt.p3 = p3_nxt_w;
    st_nxt.p4_out = st_r.p4_dat;
    st_nxt.p4_oe = p4_live_w;
    st_nxt.ud_in = st_r.ud_sel & p3_in_w[1];
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o = st_r.rdata;
  assign wb_ack_o = st_r.ack;
  assign p3_pin_o = st_r.p3.out;
  assign p3_pin_oe = st_r.p3.oe;
  assign p3_pullup_o = st_r.p3.pu;
  assign p4_pin_o = st_r.p4_out;
  assign p4_pin_oe = st_r.p4_oe;
  assign count_dir_o = st_r.ud_in;

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  logic p4_rd_go;
  logic p4d_rd_go;
  assign p4_rd_go = first_w & ~wb_we_i & hit(wb_adr_i, iop_pkg::IDX_P4_DATA);
  assign p4d_rd_go = first_w & ~wb_we_i & hit(wb_adr_i, iop_pkg::IDX_P4_DIR);

  ud_select_a: assert property (
    (st_r.ud_sel && !iop_pkg::mode_standby(st_r.mode))
    |=> (!p3_pin_oe[1] && count_dir_o == $past(p3_in_w[1])))
    else $error("count input pin not released or not passed on");

  pwm_select_a: assert property (
    (st_r.pwm_sel && !iop_pkg::mode_standby(st_r.mode))
    |=> (p3_pin_oe[0] && p3_pin_o[0] == $past(pwm_level_i)))
    else $error("pulse output pin does not follow pwm level");

  gp_dir_a: assert property (
    (!st_r.pwm_sel && !st_r.ud_sel && st_r.mode == iop_pkg::MODE_ACTIVE)
    |=> (p3_pin_oe[1:0] == $past(st_r.p3_dir[1:0])))
    else $error("port 3 low pins ignore direction");

  standby_float_a: assert property (
    iop_pkg::mode_standby(st_r.mode) |=> (p3_pin_oe == p3_pullup_o))
    else $error("port 3 drives in standby without pull-up");

  standby_high_a: assert property (
    iop_pkg::mode_standby(st_r.mode) |=> ((p3_pin_o & p3_pullup_o) == p3_pullup_o))
    else $error("pulled-up pin not high in standby");

  hold_state_a: assert property (
    iop_pkg::mode_holds(st_r.mode)
    |=> ($stable(p3_pin_oe[7:3]) && $stable(p3_pin_o[7:3])))
    else $error("port 3 upper pins change in a holding mode");

  active_live_a: assert property (
    (st_r.mode == iop_pkg::MODE_ACTIVE)
    |=> (p3_pin_oe[7:3] == $past(st_r.p3_dir[7:3])
         && p3_pin_o[7:3] == $past(st_r.p3_dat[7:3])))
    else $error("port 3 upper pins not functional when active");

  pullup_rule_a: assert property (
    1'b1 |=> (p3_pullup_o == $past(~st_r.p3_dir & st_r.p3_puc)))
    else $error("pull-up does not match direction and control");

  pullup_reset_a: assert property (
    $rose(resetn) |-> (p3_pullup_o == 8'h00 && st_r.p3_puc == 8'h00))
    else $error("pull-up on after reset");

  p4_reset_a: assert property (
    $rose(resetn) |-> (st_r.p4_dat == 3'h0 && st_r.p4_dir == 3'h0 && p4_pin_oe == 3'h0))
    else $error("port 4 not at reset values");

  p4_read_fix_a: assert property (
    p4_rd_go |=> (wb_ack_o && wb_dat_o[7:4] == 4'hf && wb_dat_o[3] == $past(p4_in3_w)))
    else $error("port 4 fixed or input-only bits read wrong");

  p4_read_mix_a: assert property (
    p4_rd_go |=> (wb_dat_o[2:0] == (($past(p4_live_w) & $past(st_r.p4_dat))
                                    | (~$past(p4_live_w) & $past(p4_in_w)))))
    else $error("port 4 read mixes latch and pin wrongly");

  p4_dir_read_a: assert property (
    p4d_rd_go |=> (wb_ack_o && wb_dat_o == 32'h0000_00ff))
    else $error("port 4 direction does not read all ones");

  p4_drive_a: assert property (
    1'b1 |=> (p4_pin_oe == $past(st_r.p4_dir & st_r.ser_gp)
              && p4_pin_o == $past(st_r.p4_dat)))
    else $error("port 4 pin drive does not follow settings");

  ack_pulse_a: assert property (
    (wb_ack_o && wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack held past one cycle");

  // every request is answered once, and only a request is answered
  ack_answer_a: assert property (
    first_w |=> wb_ack_o)
    else $error("request not answered in the next cycle");

  ack_idle_a: assert property (
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without a request");

  rdata_hold_a: assert property (
    wb_ack_o |=> $stable(wb_dat_o))
    else $error("read data changed right after ack");

  ack_reset_a: assert property (
    $rose(resetn) |-> (!wb_ack_o && wb_dat_o == 32'h0000_0000))
    else $error("bus outputs not clear after reset");

  p4_data_wr_a: assert property (
    (wr_w && hit(wb_adr_i, iop_pkg::IDX_P4_DATA)) |=> (st_r.p4_dat == $past(wd_w[2:0])))
    else $error("port 4 data write lost");

  p4_dir_wr_a: assert property (
    (wr_w && hit(wb_adr_i, iop_pkg::IDX_P4_DIR)) |=> (st_r.p4_dir == $past(wd_w[2:0])))
    else $error("port 4 direction write lost");

  gp_wr_a: assert property (
    (wr_w && hit(wb_adr_i, iop_pkg::IDX_SER_GP)) |=> (st_r.ser_gp == $past(wd_w[2:0])))
    else $error("general use select write lost");

  mode_wr_a: assert property (
    (wr_w && hit(wb_adr_i, iop_pkg::IDX_PWR)) |=> (st_r.mode == $past(wd_w[2:0])))
    else $error("power mode write lost");

  p4_gp_off_a: assert property (
    1'b1 |=> ((p4_pin_oe & ~$past(st_r.ser_gp)) == 3'h0))
    else $error("port 4 pin driven while given to the serial unit");

  reset_float_a: assert property (
    $rose(resetn) |-> (p3_pin_oe == 8'h00 && p4_pin_oe == 3'h0))
    else $error("pins driven right after reset");

  sub_live_a: assert property (
    (st_r.mode == iop_pkg::MODE_SUBACTIVE)
    |=> (p3_pin_oe[7:3] == $past(st_r.p3_dir[7:3])
         && p3_pin_o[7:3] == $past(st_r.p3_dat[7:3])))
    else $error("port 3 upper pins not functional when subactive");

  hold_low_live_a: assert property (
    (iop_pkg::mode_holds(st_r.mode) && !st_r.pwm_sel && !st_r.ud_sel)
    |=> (p3_pin_oe[2:0] == $past(st_r.p3_dir[2:0]) && p3_pin_o[2:0] == $past(st_r.p3_dat[2:0])))
    else $error("port 3 low pins not live in a holding mode");

  count_idle_a: assert property (
    !st_r.ud_sel |=> !count_dir_o)
    else $error("count input passed on while not selected");

  gp_out_a: assert property (
    (!st_r.pwm_sel && !st_r.ud_sel && st_r.mode == iop_pkg::MODE_ACTIVE)
    |=> (p3_pin_o[1:0] == $past(st_r.p3_dat[1:0])))
    else $error("port 3 low pins ignore their data latch");

endmodule

// ### hdl/iop_pkg.sv
// shared constants, types and decode helpers for the port 3 / port 4 block
package iop_pkg;

  localparam int ADR_W = 18;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_P4_DATA = 16'hffd7;
  localparam logic [15:0] IDX_P4_DIR = 16'hffe7;
  localparam logic [15:0] IDX_P3_DATA = 16'hfff0;
  localparam logic [15:0] IDX_P3_DIR = 16'hfff1;
  localparam logic [15:0] IDX_P3_PUC = 16'hfff2;
  localparam logic [15:0] IDX_P3_FUNC = 16'hfff3;
  localparam logic [15:0] IDX_SER_GP = 16'hfff4;
  localparam logic [15:0] IDX_PWR = 16'hfff5;

  // field positions in the port 3 function mode register
  localparam int FUNC_PWM_BIT = 0;
  localparam int FUNC_UD_BIT = 1;
  // lowest port 3 pin that keeps its state in the holding modes
  localparam int P3_RETAIN_LO = 3;

  // reset and fixed read values
  localparam logic [7:0] P4_DATA_RST = 8'hf8;
  localparam logic [7:0] P4_DIR_RST = 8'hf8;
  localparam logic [7:0] P3_RST = 8'h00;
  localparam logic [2:0] SER_GP_RST = 3'h7;
  localparam logic [3:0] P4_RD_HIGH = 4'hf;
  localparam logic [7:0] P4_DIR_RD = 8'hff;

  typedef enum logic [2:0] {
    MODE_ACTIVE = 3'h0,
    MODE_SUBACTIVE = 3'h1,
    MODE_SLEEP = 3'h2,
    MODE_SUBSLEEP = 3'h3,
    MODE_WATCH = 3'h4,
    MODE_STANDBY = 3'h5
  } iop_mode_e;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
  } iop_pin_s;

  typedef struct packed {
    logic [11:0] meta;
    logic [11:0] q;
  } iop_sync_s;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [7:0] p3_dat;
    logic [7:0] p3_dir;
    logic [7:0] p3_puc;
    logic pwm_sel;
    logic ud_sel;
    logic [2:0] p4_dat;
    logic [2:0] p4_dir;
    logic [2:0] ser_gp;
    iop_mode_e mode;
    iop_pin_s p3;
    logic [2:0] p4_out;
    logic [2:0] p4_oe;
    logic ud_in;
  } iop_state_s;

  function automatic logic mode_holds(input iop_mode_e m);
    logic h;
    h = 1'b0;
    unique case (m)
      MODE_SLEEP, MODE_SUBSLEEP, MODE_WATCH: h = 1'b1;
      MODE_ACTIVE, MODE_SUBACTIVE, MODE_STANDBY: h = 1'b0;
      default: h = 1'b0;
    endcase
    return h;
  endfunction

  function automatic logic mode_standby(input iop_mode_e m);
    return m == MODE_STANDBY;
  endfunction

endpackage

// ### hdl/iop_sync2.sv
// two-stage synchroniser for all port input pins
`timescale 1ns/1ps
module iop_sync2 (
  input logic sys_clk,
  input logic resetn,
  input logic [11:0] d,
  output logic [11:0] q
);

  iop_pkg::iop_sync_s st_r;
  iop_pkg::iop_sync_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = d;
    st_nxt.q = st_r.meta;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.q;

endmodule

// ### hdl/iop_p3_pins.sv
// next drive, enable and pull-up for the eight port 3 pins
`timescale 1ns/1ps
module iop_p3_pins (
  input logic [7:0] dir,
  input logic [7:0] dat,
  input logic [7:0] puc,
  input logic pwm_sel,
  input logic ud_sel,
  input logic pwm_level,
  input iop_pkg::iop_mode_e mode,
  input iop_pkg::iop_pin_s prev,
  output iop_pkg::iop_pin_s nxt
);

  logic [7:0] f_oe;
  logic [7:0] f_out;
  logic [7:0] pu_w;
  logic [7:0] oe_w;
  logic [7:0] out_w;
  logic hold;
  logic stby;

  assign hold = iop_pkg::mode_holds(mode);
  assign stby = iop_pkg::mode_standby(mode);
  assign f_oe = {dir[7:2], ~ud_sel & dir[1], pwm_sel | dir[0]};
  assign f_out = {dat[7:1], pwm_sel ? pwm_level : dat[0]};

  for (genvar i = 0; i < 8; i++) begin : g_pin
    assign pu_w[i] = ~dir[i] & puc[i];
    if (i >= iop_pkg::P3_RETAIN_LO) begin : g_hold
      assign oe_w[i] = stby ? pu_w[i] : hold ? prev.oe[i] : f_oe[i];
      assign out_w[i] = stby ? pu_w[i] : hold ? prev.out[i] : f_out[i];
    end else begin : g_live
      assign oe_w[i] = stby ? pu_w[i] : f_oe[i];
      assign out_w[i] = stby ? pu_w[i] : f_out[i];
    end
  end

  assign nxt = '{out: out_w, oe: oe_w, pu: pu_w};

endmodule

// ### dv/iop_board_model.sv
// board-side model of the port 3 and port 4 pins
`timescale 1ns/1ps
module iop_board_model (
  input wire logic clash,
  input wire logic [7:0] p3_oe,
  input wire logic [7:0] p3_out,
  input wire logic [7:0] p3_pu,
  input wire logic [7:0] p3_ext,
  input wire logic [2:0] p4_oe,
  input wire logic [2:0] p4_out,
  input wire logic [2:0] p4_ext,
  input wire logic in3_ext,
  output logic [7:0] p3_lvl,
  output logic [2:0] p4_lvl,
  output logic in3_lvl
);
  // clash: the board overdrives every pin, also those that the device drives
  assign p3_lvl = clash ? p3_ext : ((p3_oe & p3_out) | (~p3_oe & (p3_pu | p3_ext)));
  assign p4_lvl = clash ? p4_ext : ((p4_oe & p4_out) | (~p4_oe & p4_ext));
  assign in3_lvl = in3_ext;
endmodule

// ### dv/io_ports_three_four_tb.sv
// register-level testbench for the port 3 / port 4 block
`timescale 1ns/1ps
module io_ports_three_four_tb;
  logic sys_clk, resetn, we, cyc, stb, ack, pwm, cdir, clash, in3_ext, in3_lvl;
  logic [17:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0] sel;
  logic [7:0] p3_ext, p3_lvl, p3_o, p3_oe, p3_pu;
  logic [2:0] p4_ext, p4_lvl, p4_o, p4_oe;
  int bad_count, tests_run, cyc_n;
  iop_pkg::iop_mode_e hold_modes[3] = '{iop_pkg::MODE_SLEEP, iop_pkg::MODE_SUBSLEEP, iop_pkg::MODE_WATCH};

  iop_ports34 uut (
    .sys_clk(sys_clk), .resetn(resetn), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .p3_pin_i(p3_lvl), .p3_pin_o(p3_o), .p3_pin_oe(p3_oe), .p3_pullup_o(p3_pu),
    .p4_pin_i(p4_lvl), .p4_in3_i(in3_lvl), .p4_pin_o(p4_o), .p4_pin_oe(p4_oe),
    .pwm_level_i(pwm), .count_dir_o(cdir)
  );

  iop_board_model board (
    .clash(clash), .p3_oe(p3_oe), .p3_out(p3_o), .p3_pu(p3_pu), .p3_ext(p3_ext),
    .p4_oe(p4_oe), .p4_out(p4_o), .p4_ext(p4_ext), .in3_ext(in3_ext),
    .p3_lvl(p3_lvl), .p4_lvl(p4_lvl), .in3_lvl(in3_lvl)
  );

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic test_done();
    if (bad_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; read data lands in q at the ack edge
  task automatic wb(input logic [15:0] idx, input logic wr, input logic [7:0] d);
    @(posedge sys_clk);
    adr <= {idx, 2'b00};
    we <= wr;
    wdat <= {24'h0, d};
    sel <= 4'h1;
    cyc <= 1'b1;
    stb <= 1'b1;
    @(posedge sys_clk);
    while (ack !== 1'b1) @(posedge sys_clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  always @(posedge sys_clk) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      bad_count++;
      test_done();
    end
  end

  initial begin
    {resetn, we, cyc, stb, pwm, clash} = '0;
    adr = '0;
    wdat = '0;
    sel = '0;
    p3_ext = 8'h00;
    p4_ext = 3'h5;
    in3_ext = 1'b1;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    chk(32'(p3_pu), 32'h0);
    chk(32'(p4_oe), 32'h0);
    wb(iop_pkg::IDX_P4_DATA, 1'b0, 8'h00);
    chk(q, 32'hfd);
    wb(iop_pkg::IDX_P4_DIR, 1'b0, 8'h00);
    chk(q, 32'hff);
    wb(iop_pkg::IDX_P4_DIR, 1'b1, 8'hff);
    wb(iop_pkg::IDX_P4_DATA, 1'b1, 8'h02);
    repeat (3) @(posedge sys_clk);
    chk(32'({p4_oe, p4_o}), 32'h3a);
    clash <= 1'b1;
    repeat (4) @(posedge sys_clk);
    wb(iop_pkg::IDX_P4_DATA, 1'b0, 8'h00);
    chk(q, 32'hfa);
    wb(iop_pkg::IDX_SER_GP, 1'b1, 8'h06);
    repeat (4) @(posedge sys_clk);
    chk(32'(p4_oe), 32'h6);
    wb(iop_pkg::IDX_P4_DATA, 1'b0, 8'h00);
    chk(q, 32'hfb);
    wb(iop_pkg::IDX_SER_GP, 1'b1, 8'h07);
    wb(iop_pkg::IDX_P4_DIR, 1'b1, 8'h00);
    clash <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(32'(p4_oe), 32'h0);
    wb(16'h1234, 1'b1, 8'hff);
    wb(16'h1234, 1'b0, 8'h00);
    chk(q, 32'h0);
    wb(iop_pkg::IDX_P3_DIR, 1'b1, 8'h02);
    wb(iop_pkg::IDX_P3_FUNC, 1'b1, 8'h03);
    for (int lvl = 1; lvl >= 0; lvl--) begin
      pwm <= 1'(lvl);
      p3_ext <= {6'h0, 1'(lvl), 1'b0};
      repeat (5) @(posedge sys_clk);
      chk(32'({p3_oe[1:0], p3_o[0], cdir}), 32'({2'b01, 1'(lvl), 1'(lvl)}));
    end
    wb(iop_pkg::IDX_P3_FUNC, 1'b1, 8'h00);
    wb(iop_pkg::IDX_P3_DATA, 1'b1, 8'h02);
    repeat (3) @(posedge sys_clk);
    chk(32'({p3_oe[1:0], p3_o[1], cdir}), 32'ha);
    wb(iop_pkg::IDX_P3_DIR, 1'b1, 8'hff);
    foreach (hold_modes[i]) begin
      wb(iop_pkg::IDX_PWR, 1'b1, 8'(iop_pkg::MODE_ACTIVE));
      wb(iop_pkg::IDX_P3_DATA, 1'b1, 8'haa);
      wb(iop_pkg::IDX_PWR, 1'b1, 8'(hold_modes[i]));
      wb(iop_pkg::IDX_P3_DATA, 1'b1, 8'h55);
      repeat (3) @(posedge sys_clk);
      chk(32'({p3_oe, p3_o}), 32'hffad);
    end
    wb(iop_pkg::IDX_PWR, 1'b1, 8'(iop_pkg::MODE_SUBACTIVE));
    repeat (3) @(posedge sys_clk);
    chk(32'(p3_o), 32'h55);
    wb(iop_pkg::IDX_P3_DIR, 1'b1, 8'h0f);
    wb(iop_pkg::IDX_P3_PUC, 1'b1, 8'hff);
    repeat (3) @(posedge sys_clk);
    chk(32'(p3_pu), 32'hf0);
    wb(iop_pkg::IDX_PWR, 1'b1, 8'(iop_pkg::MODE_STANDBY));
    repeat (3) @(posedge sys_clk);
    chk(32'({p3_oe, p3_o}), 32'hf0f0);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(32'({p3_oe, p4_oe, p3_pu}), 32'h0);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(32'(p3_pu), 32'h0);
    wb(iop_pkg::IDX_P4_DIR, 1'b1, 8'hff);
    wb(iop_pkg::IDX_P4_DATA, 1'b0, 8'h00);
    chk(q, 32'hf8);
    test_done();
  end
endmodule
